// ### common/laser_pkg.sv
// How it works
// - Two drive modes chosen by one bit
// - Continuous mode: laser on unless powered down
// - Gated mode: laser on only during exposure
// - Gated mode after reset; host keeps it
// - Short at bin pin or laser pin to gnd kills drive, disconnect
// - Disconnect output low in normal operation
// - Config A write starts laser pin test
// - Host loads 1986-byte image after reset
// - No laser drive or navigation until image fully loaded
// - Host sources image from its own store
// - Host calibrates in continuous mode, both configs
// - Power-down input is active low
package laser_pkg;
  // ****************************************
  // Sizes and reset values
  // ****************************************
  localparam int unsigned IMAGE_BYTES = 1986;
  localparam int unsigned IMG_AW = 11;
  localparam logic MODE_RST = 1'b0;
  localparam logic MODE_CONT = 1'b1;
  localparam logic MODE_GATED = 1'b0;
  localparam logic [7:0] CFG_A_RST = 8'h00;
  localparam logic [7:0] CFG_B_RST = 8'h00;
  // Self-test phase length in core cycles
  localparam int unsigned TEST_PHASE_CYC = 4;
  localparam logic [2:0] TEST_PHASE_CNT = 3'(TEST_PHASE_CYC);
  // Config write port addresses
  localparam logic [1:0] ADR_MODE = 2'h0;
  localparam logic [1:0] ADR_CFG_A = 2'h1;
  localparam logic [1:0] ADR_CFG_B = 2'h2;
  localparam logic [1:0] ADR_IMAGE = 2'h3;
endpackage

// ### common/laser_if.sv
`timescale 1ns/1ps
`default_nettype none
// Host-to-sensor link: write strobe with address and byte, plus pins
interface laser_if;
  logic wr_stb;
  logic [1:0] wr_adr;
  logic [7:0] wr_dat;
  logic wr_rdy;
  logic powerdown_pin_n;
  logic image_loaded;
  logic fault;
  logic test_busy;
  modport sensor(input wr_stb, wr_adr, wr_dat, powerdown_pin_n,
                 output wr_rdy, image_loaded, fault, test_busy);
  modport host(output wr_stb, wr_adr, wr_dat, powerdown_pin_n,
               input wr_rdy, image_loaded, fault, test_busy);
endinterface
`default_nettype wire

// ### hw/laser_sensor.sv
`timescale 1ns/1ps
`default_nettype none
module laser_sensor (
  input wire logic core_clk, // 100 MHz core clock
  input wire logic rst, // Synchronous reset, active high
  laser_if.sensor lnk, // Host link
  input wire logic frame_expose, // Exposure window from frame timer
  input wire logic bin_short_raw, // Async comparator: bin pin shorted
  input wire logic current_short_raw, // Async comparator: laser pin to gnd
  input wire logic current_high_raw, // Async comparator: laser pin to supply
  input wire logic detector_ok_raw, // Async detector self-check reply
  output logic laser_drive_en, // Laser current source enable
  output logic laser_supply_disconnect, // Active high turns PNP off
  output logic detector_stim, // Injects fault into detector during the detector phase of the test
  output logic [7:0] power_a, // Applied power config A
  output logic [7:0] power_b, // Applied power config B
  output logic nav_enable // Navigation core may run
);
  typedef enum logic [1:0] {T_IDLE, T_GND, T_SUP, T_DET} test_t;

  logic [7:0] image_mem [laser_pkg::IMAGE_BYTES];
  logic [laser_pkg::IMG_AW-1:0] img_cnt_r;
  logic loaded_r, mode_r, fault_r;
  logic [7:0] cfg_a_r, cfg_b_r;
  test_t tst_r, tst_nxt;
  logic [2:0] tcnt_r;
  logic [3:0] s1_r, s2_r;
  logic pd_s1_r, pd_s2_r;

  // ****************************************
  // Input synchronisers
  // ****************************************
  always_ff @(posedge core_clk) begin
    s1_r <= {detector_ok_raw, current_high_raw, current_short_raw,
             bin_short_raw};
    s2_r <= s1_r;
    pd_s1_r <= lnk.powerdown_pin_n;
    pd_s2_r <= pd_s1_r;
  end
  // Only the second stage is read below: the first may be metastable.
  // The two-cycle lag means a short is cut three cycles after it
  // appears, which is well inside the time a shorted pin needs to
  // push the laser past its power limit.

  wire powered_up = pd_s2_r;
  wire wr_mode = lnk.wr_stb && lnk.wr_adr == laser_pkg::ADR_MODE;
  wire wr_a = lnk.wr_stb && lnk.wr_adr == laser_pkg::ADR_CFG_A;
  wire wr_b = lnk.wr_stb && lnk.wr_adr == laser_pkg::ADR_CFG_B;
  wire wr_img = lnk.wr_stb && lnk.wr_adr == laser_pkg::ADR_IMAGE;
  wire img_last = img_cnt_r ==
      laser_pkg::IMG_AW'(laser_pkg::IMAGE_BYTES - 1);
  wire phase_end = tcnt_r == laser_pkg::TEST_PHASE_CNT - 3'h1;
  // Test failures: short seen on pin, or detector not answering stim
  wire t_fail = (tst_r == T_GND && s2_r[1]) ||
                (tst_r == T_SUP && s2_r[2]) ||
                (tst_r == T_DET && phase_end && !s2_r[3]);
  wire cont_fault = s2_r[0] || s2_r[1];
  wire gate = (mode_r == laser_pkg::MODE_CONT) ? 1'b1 : frame_expose;

  // ****************************************
  // Image download; drive and navigation wait until full
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      img_cnt_r <= '0;
      loaded_r <= 1'b0;
    end else if (wr_img && !loaded_r) begin
      img_cnt_r <= img_cnt_r + 1'b1;
      if (img_last) begin
        loaded_r <= 1'b1;
      end
    end
  end
  // Memory has no reset: content is only valid once loaded
  always_ff @(posedge core_clk) begin
    if (wr_img && !loaded_r) begin
      image_mem[img_cnt_r] <= lnk.wr_dat;
    end
  end

  // ****************************************
  // Configuration writes
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_r <= laser_pkg::MODE_RST;
      cfg_a_r <= laser_pkg::CFG_A_RST;
      cfg_b_r <= laser_pkg::CFG_B_RST;
    end else begin
      if (wr_mode) begin
        mode_r <= lnk.wr_dat[0];
      end
      if (wr_a) begin
        cfg_a_r <= lnk.wr_dat;
      end
      if (wr_b) begin
        cfg_b_r <= lnk.wr_dat;
      end
    end
  end

  // ****************************************
  // Self-test sequencer, restarted by each A write
  // ****************************************
  always_comb begin
    tst_nxt = tst_r;
    if (wr_a) begin
      tst_nxt = T_GND;
    end else if (phase_end || t_fail) begin
      case (tst_r)
        T_GND: tst_nxt = t_fail ? T_IDLE : T_SUP;
        T_SUP: tst_nxt = t_fail ? T_IDLE : T_DET;
        T_DET: tst_nxt = T_IDLE;
        default: tst_nxt = T_IDLE;
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tst_r <= T_IDLE;
      tcnt_r <= 3'h0;
    end else begin
      tst_r <= tst_nxt;
      tcnt_r <= (tst_nxt != tst_r || wr_a) ? 3'h0 : tcnt_r + 3'h1;
    end
  end

  // Fault is sticky until reset, so a glitching short cannot re-arm it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fault_r <= 1'b0;
    end else if (cont_fault || t_fail) begin
      fault_r <= 1'b1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      laser_drive_en <= 1'b0;
      laser_supply_disconnect <= 1'b0;
      power_a <= laser_pkg::CFG_A_RST;
      power_b <= laser_pkg::CFG_B_RST;
      nav_enable <= 1'b0;
    end else begin
      laser_drive_en <= loaded_r && powered_up && gate && !fault_r &&
                        !cont_fault && tst_r == T_IDLE;
      laser_supply_disconnect <= fault_r || cont_fault;
      power_a <= cfg_a_r;
      power_b <= cfg_b_r;
      nav_enable <= loaded_r && powered_up;
    end
  end

  assign detector_stim = tst_r == T_DET;
  assign lnk.wr_rdy = 1'b1;
  assign lnk.image_loaded = loaded_r;
  assign lnk.fault = fault_r;
  assign lnk.test_busy = tst_r != T_IDLE;
endmodule
`default_nettype wire

// ### hw/laser_host.sv
`timescale 1ns/1ps
`default_nettype none
module laser_host (
  input wire logic core_clk, // 100 MHz core clock
  input wire logic rst, // Synchronous reset, active high
  laser_if.host lnk, // Link to sensor
  input wire logic img_valid, // Image byte from store is valid
  input wire logic [7:0] img_byte, // Image byte from store
  output logic img_ready, // Host takes the byte this cycle
  input wire logic cal_req, // Start a calibration pass
  input wire logic [7:0] cal_a, // Config A for calibration
  input wire logic [7:0] cal_b, // Config B for calibration
  input wire logic sleep_req, // Request laser power-down
  output logic busy // Download or calibration in progress
);
  typedef enum logic [2:0] {H_LOAD, H_IDLE, H_CMODE, H_A, H_B,
                            H_GMODE} hst_t;
  hst_t st_r, st_nxt;
  logic [laser_pkg::IMG_AW-1:0] cnt_r;
  logic stb_r, pd_r;
  logic [1:0] adr_r;
  logic [7:0] dat_r;
  wire last = cnt_r == laser_pkg::IMG_AW'(laser_pkg::IMAGE_BYTES - 1);

  // ****************************************
  // Sequence: download, then calibrations
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      H_LOAD: st_nxt = (img_valid && last) ? H_IDLE : H_LOAD;
      H_IDLE: st_nxt = cal_req ? H_CMODE : H_IDLE;
      H_CMODE: st_nxt = H_A;
      H_A: st_nxt = H_B;
      H_B: st_nxt = H_GMODE;
      H_GMODE: st_nxt = H_IDLE;
      default: st_nxt = H_IDLE;
    endcase
  end
  assign img_ready = st_r == H_LOAD;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= H_LOAD;
      cnt_r <= '0;
      stb_r <= 1'b0;
      adr_r <= laser_pkg::ADR_MODE;
      dat_r <= 8'h00;
      pd_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      pd_r <= !sleep_req;
      stb_r <= (st_r == H_LOAD && img_valid) ||
               (st_r != H_LOAD && st_r != H_IDLE);
      if (st_r == H_LOAD && img_valid) begin
        cnt_r <= cnt_r + 1'b1;
      end
      case (st_r)
        H_LOAD: begin
          adr_r <= laser_pkg::ADR_IMAGE;
          dat_r <= img_byte;
        end
        H_CMODE: begin
          adr_r <= laser_pkg::ADR_MODE;
          dat_r <= {7'h00, laser_pkg::MODE_CONT};
        end
        H_A: begin
          adr_r <= laser_pkg::ADR_CFG_A;
          dat_r <= cal_a;
        end
        H_B: begin
          adr_r <= laser_pkg::ADR_CFG_B;
          dat_r <= cal_b;
        end
        H_GMODE: begin
          adr_r <= laser_pkg::ADR_MODE;
          dat_r <= {7'h00, laser_pkg::MODE_GATED};
        end
        default: begin
          adr_r <= adr_r;
          dat_r <= dat_r;
        end
      endcase
    end
  end

  assign lnk.wr_stb = stb_r;
  assign lnk.wr_adr = adr_r;
  assign lnk.wr_dat = dat_r;
  assign lnk.powerdown_pin_n = pd_r;
  assign busy = st_r != H_IDLE;
endmodule
`default_nettype wire

// ### bench/laser_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Link checker
// ****
module laser_link_checker (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Sync reset
  input wire logic wr_stb, // Write strobe
  input wire logic [1:0] wr_adr, // Write target
  input wire logic [7:0] wr_dat, // Write data
  input wire logic wr_rdy, // Sensor ready
  input wire logic image_loaded, // Image complete
  input wire logic fault, // Latched fault
  input wire logic test_busy // Self-test running
);
  logic [11:0] img_cnt_r;
  logic [11:0] img_cnt_nxt;
  wire img_wr = wr_stb && wr_adr == laser_pkg::ADR_IMAGE;
  wire a_wr = wr_stb && wr_adr == laser_pkg::ADR_CFG_A;
  wire b_wr = wr_stb && wr_adr == laser_pkg::ADR_CFG_B;
  wire mode_wr = wr_stb && wr_adr == laser_pkg::ADR_MODE;
  wire full = img_cnt_r >= 12'(laser_pkg::IMAGE_BYTES);
  // Saturate so that stray late bytes cannot wrap the count
  assign img_cnt_nxt = (img_wr && !full) ? img_cnt_r + 12'h001 : img_cnt_r;
  always_ff @(posedge core_clk) begin
    img_cnt_r <= rst ? 12'h000 : img_cnt_nxt;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence cal_rest;
    a_wr ##1 b_wr ##1 (mode_wr && wr_dat[0] == laser_pkg::MODE_GATED);
  endsequence
  AST_RDY: assert property (wr_rdy)
    else $error("sensor stalled");
  AST_FAULT_HOLD: assert property (fault |=> fault)
    else $error("fault cleared");
  AST_LOADED_HOLD: assert property (image_loaded |=> image_loaded)
    else $error("image lost");
  AST_NO_EARLY: assert property (image_loaded |-> full)
    else $error("loaded early");
  AST_LOAD_DONE: assert property (full |-> ##[0:2] image_loaded)
    else $error("load not flagged");
  AST_TEST_START: assert property (a_wr |=> test_busy [*8])
    else $error("test not started");
  AST_TEST_CAUSE: assert property (!test_busy && !a_wr |=> !test_busy)
    else $error("test without write");
  AST_CAL: assert property (
    mode_wr && wr_dat[0] == laser_pkg::MODE_CONT |=> cal_rest)
    else $error("calibration order");
endmodule
`default_nettype wire

// ### bench/laser_drive_fault_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench top
// ****
module laser_drive_fault_control_tb;
  logic core_clk, rst, frame_expose, bin_short_raw, current_short_raw;
  logic current_high_raw, img_valid, cal_req, sleep_req, busy, img_ready;
  logic laser_drive_en, laser_supply_disconnect, detector_stim, nav_enable;
  logic [7:0] img_byte, power_a, power_b;
  int errors, samples_checked, cyc;
  laser_if lnk();
  // A healthy detector echoes the injected stimulus
  laser_sensor i_laser_sensor (.core_clk(core_clk), .rst(rst),
    .lnk(lnk.sensor), .frame_expose(frame_expose),
    .bin_short_raw(bin_short_raw), .current_short_raw(current_short_raw),
    .current_high_raw(current_high_raw), .detector_ok_raw(detector_stim),
    .laser_drive_en(laser_drive_en), .detector_stim(detector_stim),
    .laser_supply_disconnect(laser_supply_disconnect), .power_a(power_a),
    .power_b(power_b), .nav_enable(nav_enable));
  laser_host i_laser_host (.core_clk(core_clk), .rst(rst), .lnk(lnk.host),
    .img_valid(img_valid), .img_byte(img_byte), .img_ready(img_ready),
    .cal_req(cal_req), .cal_a(8'h5a), .cal_b(8'ha5),
    .sleep_req(sleep_req), .busy(busy));
  laser_link_checker i_laser_link_checker (.core_clk(core_clk), .rst(rst),
    .wr_stb(lnk.wr_stb), .wr_adr(lnk.wr_adr), .wr_dat(lnk.wr_dat),
    .wr_rdy(lnk.wr_rdy), .image_loaded(lnk.image_loaded),
    .fault(lnk.fault), .test_busy(lnk.test_busy));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Two boots of about 2000 cycles each fit well under the ceiling
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      final_report();
    end
  end
  task automatic chk(input logic got, input logic exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Reset, then stream the image until the sensor reports it complete
  task automatic boot();
    rst = 1'b1;
    cycles(10);
    rst = 1'b0;
    chk(lnk.image_loaded, 1'b0, "loaded at reset");
    chk(laser_supply_disconnect, 1'b0, "disconnect at reset");
    cycles(1);
    chk(img_ready, 1'b1, "host not loading");
    img_valid = 1'b1;
    for (int i = 0; i < 6000 && lnk.image_loaded !== 1'b1; i++) begin
      cycles(1);
    end
    img_valid = 1'b0;
    cycles(3);
    chk(lnk.image_loaded, 1'b1, "image not loaded");
    chk(nav_enable, 1'b1, "navigation idle");
  endtask
  // Pass 0 calibrates and faults the bin pin; pass 1 faults the laser pin
  initial begin
    {rst, frame_expose, bin_short_raw, current_short_raw} = 4'hf;
    {current_high_raw, img_valid, cal_req, sleep_req} = 4'h0;
    {bin_short_raw, current_short_raw, frame_expose} = 3'h0;
    img_byte = 8'h3c;
    errors = 0;
    samples_checked = 0;
    cyc = 0;
    for (int k = 0; k < 2; k++) begin
      boot();
      frame_expose = 1'b1;
      cycles(4);
      chk(laser_drive_en, 1'b1, "dark in window");
      frame_expose = 1'b0;
      cycles(4);
      chk(laser_drive_en, 1'b0, "lit outside window");
      if (k == 0) begin
        cal_req = 1'b1;
        cycles(1);
        cal_req = 1'b0;
        for (int i = 0; i < 100 && busy !== 1'b0; i++) begin
          cycles(1);
        end
        cycles(16);
        chk(power_a == 8'h5a, 1'b1, "power a");
        chk(power_b == 8'ha5, 1'b1, "power b");
        chk(lnk.fault, 1'b0, "self-test false alarm");
        chk(busy, 1'b0, "host still busy");
        {sleep_req, frame_expose} = 2'h3;
        cycles(4);
        chk(lnk.powerdown_pin_n, 1'b0, "no power-down");
        chk(laser_drive_en, 1'b0, "lit in power-down");
        {sleep_req, frame_expose, bin_short_raw} = 3'h1;
      end else begin
        current_short_raw = 1'b1;
      end
      cycles(5);
      chk(laser_supply_disconnect, 1'b1, "short not cut");
      chk(lnk.fault, 1'b1, "short not flagged");
      {bin_short_raw, current_short_raw, frame_expose} = 3'h1;
      cycles(5);
      chk(laser_drive_en, 1'b0, "lit after fault");
      chk(laser_supply_disconnect, 1'b1, "fault released");
      frame_expose = 1'b0;
    end
    final_report();
  end
endmodule
`default_nettype wire
